// >>> rtl/asfw_consts.svh
// bit positions, widths and reset values of the alu status flag register
`ifndef ASFW_CONSTS_SVH
`define ASFW_CONSTS_SVH

`define ASFW_DATA_W     8
`define ASFW_FLAG_W     5
`define ASFW_BIT_C      0
`define ASFW_BIT_DC     1
`define ASFW_BIT_Z      2
`define ASFW_BIT_OV     3
`define ASFW_BIT_N      4
`define ASFW_STATUS_RST 8'h00
`define ASFW_UPPER_ZERO 3'h0
`define ASFW_NO_FLAGS   5'h00
`define ASFW_ALL_FLAGS  5'h1f
`define ASFW_NZ_FLAGS   5'h14
`define ASFW_Z_FLAG     5'h04

`endif

// >>> rtl/asfw_pkg.sv
// types shared by the status flag writeback block
package asfw_pkg;

    typedef enum logic [2:0] {
        ASFW_OP_ADD,
        ASFW_OP_SUB,
        ASFW_OP_AND,
        ASFW_OP_IOR,
        ASFW_OP_XOR,
        ASFW_OP_CLR,
        ASFW_OP_MOVF,
        ASFW_OP_WRITE
    } asfw_op_e;

endpackage

// >>> rtl/asfw_flag_calc.sv
// alu result, flag values and flag-affect mask for one operation
`timescale 1ns/10ps
`default_nettype none
`include "asfw_consts.svh"

module asfw_flag_calc
    import asfw_pkg::*;
(
    input  wire asfw_op_e                 op,
    input  wire logic [`ASFW_DATA_W-1:0]  opa,
    input  wire logic [`ASFW_DATA_W-1:0]  opb,
    output logic      [`ASFW_DATA_W-1:0]  res,
    output logic      [`ASFW_FLAG_W-1:0]  flags,
    output logic      [`ASFW_FLAG_W-1:0]  affect
);

    logic [8:0] sum9;
    logic [4:0] sum5;
    logic [7:0] bsel;
    logic       cin;

    always_comb begin
        // subtraction adds the inverted operand plus one
        cin  = (op == ASFW_OP_SUB);
        bsel = cin ? ~opb : opb;
        sum9 = {1'b0, opa} + {1'b0, bsel} + {8'h00, cin};
        sum5 = {1'b0, opa[3:0]} + {1'b0, bsel[3:0]} + {4'h0, cin};
        res    = 8'h00;
        affect = `ASFW_NO_FLAGS;
        flags  = `ASFW_NO_FLAGS;
        case (op)
            ASFW_OP_ADD, ASFW_OP_SUB: begin
                res    = sum9[7:0];
                affect = `ASFW_ALL_FLAGS;
                // carry out doubles as active-low borrow on subtract
                flags[`ASFW_BIT_C]  = sum9[8];
                flags[`ASFW_BIT_DC] = sum5[4];
                flags[`ASFW_BIT_OV] = (opa[7] == bsel[7]) && (sum9[7] != opa[7]);
            end
            ASFW_OP_AND: begin
                res    = opa & opb;
                affect = `ASFW_NZ_FLAGS;
            end
            ASFW_OP_IOR: begin
                res    = opa | opb;
                affect = `ASFW_NZ_FLAGS;
            end
            ASFW_OP_XOR: begin
                res    = opa ^ opb;
                affect = `ASFW_NZ_FLAGS;
            end
            ASFW_OP_CLR: begin
                res    = 8'h00;
                affect = `ASFW_Z_FLAG;
            end
            ASFW_OP_MOVF: begin
                res    = opa;
                affect = `ASFW_NZ_FLAGS;
            end
            ASFW_OP_WRITE: begin
                res    = opb;
                affect = `ASFW_NO_FLAGS;
            end
            default: begin
                res    = 8'h00;
                affect = `ASFW_NO_FLAGS;
            end
        endcase
        flags[`ASFW_BIT_N] = res[7];
        flags[`ASFW_BIT_Z] = (res == 8'h00);
    end

endmodule
`default_nettype wire

// >>> rtl/asfw_top.sv
// status flag register and its write arbitration for the execute stage
// Notes on behaviour
// - flag-affecting instruction targeting status discards result; only its flag effects land.
// - clear aimed at status sets zero only, others kept: 000u u1uu.
// - on subtraction carry means not-borrow and digit carry means not-digit-borrow.
// - status register usable as source or destination of any instruction.
// - status records flags from the latest flag-affecting instruction.
// - negative flag bit 4 follows result msb.
// - overflow flag bit 3 set when signed result flips sign wrongly.
`timescale 1ns/10ps
`default_nettype none
`include "asfw_consts.svh"

module asfw_top
    import asfw_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     resetn,
    input  wire logic                     instr_valid,
    input  wire asfw_op_e                 alu_op,
    input  wire logic [`ASFW_DATA_W-1:0]  file_operand,
    input  wire logic                     src_is_status,
    input  wire logic [`ASFW_DATA_W-1:0]  work_operand,
    input  wire logic                     dest_is_status,
    output logic      [`ASFW_DATA_W-1:0]  result_q,
    output logic                          result_wr_q,
    output logic      [`ASFW_DATA_W-1:0]  status_q
);

    logic [`ASFW_DATA_W-1:0] opa;
    logic [`ASFW_DATA_W-1:0] calc_res;
    logic [`ASFW_FLAG_W-1:0] calc_flags;
    logic [`ASFW_FLAG_W-1:0] calc_affect;
    logic [`ASFW_DATA_W-1:0] result_d;
    logic                    result_wr_d;
    logic [`ASFW_DATA_W-1:0] status_d;
    logic [`ASFW_FLAG_W-1:0] flag_base;

    // status can be read as the file operand
    assign opa = src_is_status ? status_q : file_operand;

    asfw_flag_calc u_calc (
        .op     (alu_op),
        .opa    (opa),
        .opb    (work_operand),
        .res    (calc_res),
        .flags  (calc_flags),
        .affect (calc_affect)
    );

    always_comb begin
        result_d    = result_q;
        result_wr_d = 1'b0;
        status_d    = status_q;
        flag_base   = status_q[`ASFW_FLAG_W-1:0];
        if (instr_valid) begin
            if (dest_is_status) begin
                // result dropped when flags are touched
                if (calc_affect == `ASFW_NO_FLAGS) begin
                    flag_base = calc_res[`ASFW_FLAG_W-1:0];
                end
            end else begin
                result_d    = calc_res;
                result_wr_d = 1'b1;
            end
            // affected flags take the alu outcome
            status_d = {`ASFW_UPPER_ZERO,
                        (calc_affect & calc_flags) | (~calc_affect & flag_base)};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            result_q    <= 8'h00;
            result_wr_q <= 1'b0;
            status_q    <= `ASFW_STATUS_RST;
        end else begin
            result_q    <= result_d;
            result_wr_q <= result_wr_d;
            status_q    <= status_d;
        end
    end

    a_dest_discard: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && dest_is_status && (calc_affect != `ASFW_NO_FLAGS)
        |=> !result_wr_q && (result_q == $past(result_q)))
        else $error("flag-affecting status write leaked a result");

    a_clear_zero: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && dest_is_status && (alu_op == ASFW_OP_CLR)
        |=> status_q == {3'h0, $past(status_q[4:3]), 1'b1, $past(status_q[1:0])})
        else $error("clear of status did not give 000u u1uu");

    a_sub_borrow: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && (alu_op == ASFW_OP_SUB)
        |=> (status_q[`ASFW_BIT_C] == ($past(opa) >= $past(work_operand)))
            && (status_q[`ASFW_BIT_DC] == ($past(opa[3:0]) >= $past(work_operand[3:0]))))
        else $error("subtract borrow flags wrong");

    a_status_source: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && src_is_status && !dest_is_status && (alu_op == ASFW_OP_MOVF)
        |=> result_wr_q && (result_q == $past(status_q)))
        else $error("status not delivered as source operand");

    a_zero_record: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && calc_affect[`ASFW_BIT_Z]
        |=> status_q[`ASFW_BIT_Z] == ($past(calc_res) == 8'h00))
        else $error("zero flag does not match last result");

    a_neg_msb: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && calc_affect[`ASFW_BIT_N]
        |=> status_q[`ASFW_BIT_N] == $past(calc_res[7]))
        else $error("negative flag does not follow result msb");

    a_add_ovf: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && (alu_op == ASFW_OP_ADD)
        |=> status_q[`ASFW_BIT_OV] == (($past(opa[7]) == $past(work_operand[7]))
            && ($past(calc_res[7]) != $past(opa[7]))))
        else $error("overflow flag wrong on add");

    a_plain_write: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && dest_is_status && (alu_op == ASFW_OP_WRITE)
        |=> status_q == {3'h0, $past(work_operand[4:0])})
        else $error("plain write to status not stored");

    a_upper_zero: assert property (@(posedge clk) disable iff (!resetn)
        status_q[7:5] == 3'h0)
        else $error("unimplemented status bits not zero");

    a_idle_hold: assert property (@(posedge clk) disable iff (!resetn)
        !instr_valid |=> (status_q == $past(status_q)) && !result_wr_q)
        else $error("status changed without an instruction");

    a_add_carry: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && (alu_op == ASFW_OP_ADD)
        |=> (status_q[`ASFW_BIT_C] == (({1'b0, $past(opa)} + {1'b0, $past(work_operand)}) > 9'h0ff))
            && (status_q[`ASFW_BIT_DC] == (({1'b0, $past(opa[3:0])}
                + {1'b0, $past(work_operand[3:0])}) > 5'h0f)))
        else $error("add carry flags wrong");

    a_logic_keep: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && (alu_op inside {ASFW_OP_AND, ASFW_OP_IOR, ASFW_OP_XOR, ASFW_OP_MOVF})
        |=> (status_q[`ASFW_BIT_C] == $past(status_q[`ASFW_BIT_C]))
            && (status_q[`ASFW_BIT_DC] == $past(status_q[`ASFW_BIT_DC]))
            && (status_q[`ASFW_BIT_OV] == $past(status_q[`ASFW_BIT_OV])))
        else $error("logic operation disturbed carry or overflow");

    a_write_file: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && !dest_is_status && (alu_op == ASFW_OP_WRITE)
        |=> result_wr_q && (result_q == $past(work_operand))
            && (status_q == $past(status_q)))
        else $error("plain write to a file changed status or lost data");

    a_file_result: assert property (@(posedge clk) disable iff (!resetn)
        instr_valid && !dest_is_status
        |=> result_wr_q)
        else $error("result for a file destination not written");

endmodule
`default_nettype wire

// >>> verification/asfw_top_tb_top.sv
// self-checking bench for the status flag writeback block
`timescale 1ns/10ps
`default_nettype none

module asfw_top_tb_top
    import asfw_pkg::*;
;
    logic       clk = 1'b0;
    logic       resetn = 1'b0;
    logic       instr_valid = 1'b0;
    asfw_op_e   alu_op = ASFW_OP_ADD;
    logic [7:0] file_operand = 8'h00;
    logic       src_is_status = 1'b0;
    logic [7:0] work_operand = 8'h00;
    logic       dest_is_status = 1'b0;
    logic [7:0] result_q;
    logic       result_wr_q;
    logic [7:0] status_q;
    int         errors = 0;
    int         checks_done = 0;
    int         m_st = 0;
    int         m_res = 0;
    logic [7:0] exp_st;
    logic [7:0] exp_res;
    logic       exp_wr;
    bit         chk_due = 1'b0;

    asfw_top dut (.clk(clk), .resetn(resetn), .instr_valid(instr_valid), .alu_op(alu_op),
        .file_operand(file_operand), .src_is_status(src_is_status),
        .work_operand(work_operand), .dest_is_status(dest_is_status),
        .result_q(result_q), .result_wr_q(result_wr_q), .status_q(status_q));

    always #4 clk = ~clk;

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // model of one execute cycle, then drive it for the next edge
    task automatic step(input bit v, input asfw_op_e op, input int f, input bit s,
                        input int w, input bit d);
        int a, r, c, dc, ov, af, fl;
        bit wr;
        a = s ? m_st : f;
        c = 0;
        dc = 0;
        ov = 0;
        case (op)
            ASFW_OP_ADD: begin
                r = a + w;
                c = r > 255;
                dc = (a % 16 + w % 16) > 15;
                ov = ((a ^ r) & (w ^ r) & 128) != 0;
            end
            ASFW_OP_SUB: begin
                r = a - w;
                c = a >= w;
                dc = a % 16 >= w % 16;
                ov = ((a ^ w) & (a ^ r) & 128) != 0;
            end
            ASFW_OP_AND: r = a & w;
            ASFW_OP_IOR: r = a | w;
            ASFW_OP_XOR: r = a ^ w;
            ASFW_OP_CLR: r = 0;
            ASFW_OP_MOVF: r = a;
            default: r = w;
        endcase
        r = r & 255;
        af = (op inside {ASFW_OP_ADD, ASFW_OP_SUB}) ? 31 : (op == ASFW_OP_CLR) ? 4 :
             (op == ASFW_OP_WRITE) ? 0 : 20;
        fl = (r / 128) * 16 + ov * 8 + (r == 0) * 4 + dc * 2 + c;
        wr = v && !d;
        if (v && d && af == 0) m_st = w % 32;
        else if (v) m_st = (m_st & ~af) | (fl & af);
        if (wr) m_res = r;
        instr_valid <= v;
        alu_op <= op;
        file_operand <= f[7:0];
        src_is_status <= s;
        work_operand <= w[7:0];
        dest_is_status <= d;
        @(posedge clk);
        exp_st = m_st[7:0];
        exp_res = m_res[7:0];
        exp_wr = wr;
        chk_due = 1'b1;
    endtask

    always @(negedge clk) begin
        if (chk_due) begin
            check("status_q", status_q, exp_st);
            check("result_q", result_q, exp_res);
            check("result_wr_q", {7'h00, result_wr_q}, exp_wr);
            chk_due = 1'b0;
        end
    end

    task automatic rst();
        resetn <= 1'b0;
        instr_valid <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        m_st = 0;
        m_res = 0;
        exp_st = 8'h00;
        exp_res = 8'h00;
        exp_wr = 1'b0;
        chk_due = 1'b1;
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        errors++;
        summarize();
    end

    initial begin
        void'($urandom(32'hcb4b6e3b));
        @(posedge clk);
        rst();
        step(0, ASFW_OP_ADD, 0, 0, 0, 0);
        done("reset");
        step(1, ASFW_OP_ADD, 8'h7f, 0, 8'h01, 0);
        step(1, ASFW_OP_ADD, 8'hff, 0, 8'h01, 0);
        step(1, ASFW_OP_SUB, 8'h00, 0, 8'h01, 0);
        step(1, ASFW_OP_SUB, 8'h80, 0, 8'h01, 0);
        step(1, ASFW_OP_SUB, 8'h05, 0, 8'h05, 0);
        done("arith");
        step(1, ASFW_OP_WRITE, 0, 0, 8'heb, 1);
        step(1, ASFW_OP_CLR, 8'h33, 0, 0, 1);
        step(1, ASFW_OP_ADD, 8'h01, 0, 8'h01, 1);
        step(1, ASFW_OP_ADD, 0, 1, 8'h90, 0);
        step(1, ASFW_OP_MOVF, 0, 1, 0, 1);
        step(1, ASFW_OP_WRITE, 0, 0, 8'h5a, 0);
        done("status dest");
        for (int i = 0; i < 16; i++) step(1, asfw_op_e'(i % 8), 8'h9c, i[3], 8'h63, i[3]);
        done("op table");
        repeat (400) step($urandom_range(0, 1), asfw_op_e'($urandom_range(0, 7)),
                          $urandom_range(0, 255), $urandom_range(0, 1),
                          $urandom_range(0, 255), $urandom_range(0, 1));
        done("random");
        rst();
        step(0, ASFW_OP_SUB, 8'h12, 0, 8'h34, 0);
        done("second reset");
        summarize();
    end
endmodule

`default_nettype wire
